// ==== rtl/tsf_map.svh ====
`ifndef TSF_MAP_SVH
`define TSF_MAP_SVH

// Register byte offsets
`define TSF_OFS_STATUS 5'h00
`define TSF_OFS_ENABLE 5'h04
`define TSF_OFS_FSEL 5'h08
`define TSF_OFS_COUNTER 5'h0C
`define TSF_OFS_GR_A 5'h10
`define TSF_OFS_GR_B 5'h14
`define TSF_OFS_GR_C 5'h18
`define TSF_OFS_GR_D 5'h1C

// Field positions
`define TSF_WRAP_BIT 7
`define TSF_RUN_BIT 7
`define TSF_CH_LSB 0
`define TSF_CH_MSB 3
`define TSF_RSV_LSB 4
`define TSF_RSV_MSB 6

// Values
`define TSF_RSV_ONES 3'h7
`define TSF_CNT_MAX 16'hFFFF
`define TSF_CNT_ONE 16'h0001
`define TSF_ZERO16 16'h0000
`define TSF_ZERO32 32'h0000_0000
`define TSF_ZERO4 4'h0
`define TSF_ZERO8 8'h00

`endif

// ==== rtl/tsf_pkg.sv ====
package tsf_pkg;

    typedef struct packed {
        logic wrap;
        logic [3:0] ch;
    } tsf_flags_s;

    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } tsf_avs_req_s;

    typedef enum logic {
        TSF_BUS_IDLE,
        TSF_BUS_ANSWER
    } tsf_bus_e;

endpackage

// ==== rtl/tsf_top.sv ====
// Operation
// - Overflow flag (bit 7) sets when the counter wraps from FFFF to 0000.
// - Overflow flag clears only by reading it as 1, then writing 0.
// - Status bits 6 to 4 always read 1 and ignore writes.
// - Channel flag sets when counter equals its general register in compare mode.
// - Capture copies the counter into the general register and sets the flag.
// - Channel flags clear only by reading them as 1, then writing 0.
// - Wrap interrupt request is registered: high one cycle after wrap flag and its enable are both set.
// - Channel request is registered: high one cycle after its flag and matching enable are both set.
// - Function select 0 means output compare, 1 means input capture.
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "tsf_map.svh"

module tsf_top #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Avalon-MM slave
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Capture signals, one per channel A..D
    input wire logic [3:0] CAPTURE_STROBE,
    // Interrupt requests
    output logic IRQ,
    output logic WRAP_IRQ,
    output logic [3:0] CH_IRQ
);
    import tsf_pkg::*;

    tsf_avs_req_s req;
    tsf_bus_e bus_q;
    tsf_bus_e bus_d;
    logic wait_q;
    logic wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic wr_done;
    logic rd_done;

    tsf_flags_s flags_q;
    tsf_flags_s flags_d;
    tsf_flags_s armed_q;
    tsf_flags_s armed_d;
    tsf_flags_s enable_q;
    tsf_flags_s enable_d;
    logic [3:0] fsel_q;
    logic [3:0] fsel_d;
    logic run_q;
    logic run_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] gr_q [4];
    logic [CNT_W-1:0] gr_d [4];
    logic irq_q;
    logic irq_d;
    logic wrap_irq_q;
    logic wrap_irq_d;
    logic [3:0] ch_irq_q;
    logic [3:0] ch_irq_d;

    // Flag byte layout shared by status and enable registers
    function automatic logic [7:0] pack_flags(input tsf_flags_s f);
        logic [7:0] v;
        v = `TSF_ZERO8;
        v[`TSF_WRAP_BIT] = f.wrap;
        v[`TSF_RSV_MSB:`TSF_RSV_LSB] = `TSF_RSV_ONES;
        v[`TSF_CH_MSB:`TSF_CH_LSB] = f.ch;
        return v;
    endfunction

    function automatic tsf_flags_s unpack_flags(input logic [7:0] v);
        tsf_flags_s f;
        f.wrap = v[`TSF_WRAP_BIT];
        f.ch = v[`TSF_CH_MSB:`TSF_CH_LSB];
        return f;
    endfunction

    // Byte-lane merge for 16-bit registers
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [15:0] v;
        v = old;
        if (be[0]) begin
            v[7:0] = wd[7:0];
        end
        if (be[1]) begin
            v[15:8] = wd[15:8];
        end
        return v;
    endfunction

    assign req.address = AVS_ADDRESS;
    assign req.read = AVS_READ;
    assign req.write = AVS_WRITE;
    assign req.writedata = AVS_WRITEDATA;
    assign req.byteenable = AVS_BYTEENABLE;

    // Bus: one wait cycle, read data latched while waitrequest is still high
    always_comb begin
        bus_d = bus_q;
        wait_d = 1'b1;
        rdata_d = rdata_q;
        unique case (bus_q)
            TSF_BUS_IDLE: begin
                if (req.read || req.write) begin
                    bus_d = TSF_BUS_ANSWER;
                    wait_d = 1'b0;
                    rdata_d = `TSF_ZERO32;
                    if (req.read) begin
                        unique case (req.address)
                            `TSF_OFS_STATUS: rdata_d[7:0] = pack_flags(flags_q);
                            `TSF_OFS_ENABLE: rdata_d[7:0] = pack_flags(enable_q);
                            `TSF_OFS_FSEL: begin
                                rdata_d[`TSF_RUN_BIT] = run_q;
                                rdata_d[3:0] = fsel_q;
                            end
                            `TSF_OFS_COUNTER: rdata_d[15:0] = 16'(cnt_q);
                            `TSF_OFS_GR_A: rdata_d[15:0] = 16'(gr_q[0]);
                            `TSF_OFS_GR_B: rdata_d[15:0] = 16'(gr_q[1]);
                            `TSF_OFS_GR_C: rdata_d[15:0] = 16'(gr_q[2]);
                            `TSF_OFS_GR_D: rdata_d[15:0] = 16'(gr_q[3]);
                            default: rdata_d = `TSF_ZERO32;
                        endcase
                    end
                end
            end
            TSF_BUS_ANSWER: begin
                bus_d = TSF_BUS_IDLE;
            end
        endcase
    end

    assign wr_done = (bus_q == TSF_BUS_ANSWER) && req.write;
    assign rd_done = (bus_q == TSF_BUS_ANSWER) && req.read;

    always_ff @(posedge CLK) begin
        if (RST) begin
            bus_q <= TSF_BUS_IDLE;
            wait_q <= 1'b1;
            rdata_q <= `TSF_ZERO32;
        end else begin
            bus_q <= bus_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // Timer state: counter, general registers, flags and interrupts
    always_comb begin
        logic [3:0] set_ch;
        logic set_wrap;
        logic [7:0] wb;
        tsf_flags_s clr;
        logic [CNT_W-1:0] wval;
        set_ch = `TSF_ZERO4;
        set_wrap = 1'b0;
        wb = req.writedata[7:0];
        clr = unpack_flags(`TSF_ZERO8);
        wval = cnt_q;
        enable_d = enable_q;
        fsel_d = fsel_q;
        run_d = run_q;
        cnt_d = cnt_q;
        armed_d = armed_q;
        for (int i = 0; i < 4; i++) begin
            gr_d[i] = gr_q[i];
        end

        if (run_q) begin
            cnt_d = cnt_q + CNT_W'(`TSF_CNT_ONE);
            set_wrap = (cnt_q == CNT_W'(`TSF_CNT_MAX));
        end

        if (wr_done) begin
            unique case (req.address)
                `TSF_OFS_STATUS: begin
                    if (req.byteenable[0]) begin
                        // Only bits seen as 1 by an earlier read and now written 0 clear
                        clr.wrap = armed_q.wrap && !wb[`TSF_WRAP_BIT];
                        clr.ch = armed_q.ch & ~wb[`TSF_CH_MSB:`TSF_CH_LSB];
                        armed_d = unpack_flags(`TSF_ZERO8);
                    end
                end
                `TSF_OFS_ENABLE: begin
                    if (req.byteenable[0]) begin
                        enable_d = unpack_flags(wb);
                    end
                end
                `TSF_OFS_FSEL: begin
                    if (req.byteenable[0]) begin
                        run_d = wb[`TSF_RUN_BIT];
                        fsel_d = wb[3:0];
                    end
                end
                `TSF_OFS_COUNTER: begin
                    wval = CNT_W'(merge16(16'(cnt_q), req.writedata, req.byteenable));
                    cnt_d = wval;
                    set_wrap = 1'b0;
                end
                `TSF_OFS_GR_A, `TSF_OFS_GR_B, `TSF_OFS_GR_C, `TSF_OFS_GR_D: begin
                    gr_d[req.address[3:2]] = CNT_W'(merge16(16'(gr_q[req.address[3:2]]),
                        req.writedata, req.byteenable));
                end
                default: begin
                end
            endcase
        end

        // Arm on a status read with the bits the reader actually saw as 1
        if (rd_done && req.address == `TSF_OFS_STATUS) begin
            armed_d = unpack_flags(rdata_q[7:0]);
        end

        for (int i = 0; i < 4; i++) begin
            if (!fsel_q[i]) begin
                set_ch[i] = (cnt_q == gr_q[i]);
            end else if (CAPTURE_STROBE[i]) begin
                // Capture outranks a software write in the same cycle
                gr_d[i] = cnt_q;
                set_ch[i] = 1'b1;
            end
        end

        // Set wins over clear; reserved bits hold no state
        flags_d.wrap = (flags_q.wrap && !clr.wrap) || set_wrap;
        flags_d.ch = (flags_q.ch & ~clr.ch) | set_ch;

        wrap_irq_d = flags_q.wrap && enable_q.wrap;
        ch_irq_d = flags_q.ch & enable_q.ch;
        irq_d = wrap_irq_d || (|ch_irq_d);
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            flags_q <= unpack_flags(`TSF_ZERO8);
            armed_q <= unpack_flags(`TSF_ZERO8);
            enable_q <= unpack_flags(`TSF_ZERO8);
            fsel_q <= `TSF_ZERO4;
            run_q <= 1'b0;
            cnt_q <= CNT_W'(`TSF_ZERO16);
            for (int i = 0; i < 4; i++) begin
                gr_q[i] <= CNT_W'(`TSF_CNT_MAX);
            end
            irq_q <= 1'b0;
            wrap_irq_q <= 1'b0;
            ch_irq_q <= `TSF_ZERO4;
        end else begin
            flags_q <= flags_d;
            armed_q <= armed_d;
            enable_q <= enable_d;
            fsel_q <= fsel_d;
            run_q <= run_d;
            cnt_q <= cnt_d;
            for (int i = 0; i < 4; i++) begin
                gr_q[i] <= gr_d[i];
            end
            irq_q <= irq_d;
            wrap_irq_q <= wrap_irq_d;
            ch_irq_q <= ch_irq_d;
        end
    end

    assign AVS_READDATA = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign IRQ = irq_q;
    assign WRAP_IRQ = wrap_irq_q;
    assign CH_IRQ = ch_irq_q;

endmodule

`default_nettype wire

// ==== verif/tsf_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module tsf_chk (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Bus
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic AVS_WAITREQUEST,
    // Interrupts
    input wire logic IRQ,
    input wire logic WRAP_IRQ,
    input wire logic [3:0] CH_IRQ
);
    logic seen_q;
    logic seen_d;
    logic st_rd;
    logic st_wr;
    assign st_rd = AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 5'h00;
    assign st_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 5'h00;
    // A status write with byte lane 0 enabled disarms everything, so only a fresh read may clear
    always_comb begin
        seen_d = st_wr ? 1'b0 : (st_rd ? 1'b1 : seen_q);
    end
    always_ff @(posedge CLK) begin
        seen_q <= RST ? 1'b0 : seen_d;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    property p_irq_or;
        IRQ == (WRAP_IRQ || |CH_IRQ);
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq not or of requests");
    property p_ans;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
    endproperty
    a_ans: assert property (p_ans) else $error("request not answered");
    property p_one;
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
    endproperty
    a_one: assert property (p_one) else $error("waitrequest low too long");
    property p_idle;
        !AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST;
    endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_rsv;
        st_rd |-> AVS_READDATA[6:4] == 3'h7;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved status bits not ones");
    property p_unread;
        st_wr && !seen_q |-> ##2 !$fell(IRQ);
    endproperty
    a_unread: assert property (p_unread) else $error("unread flag cleared");
    property p_ones;
        st_wr && AVS_WRITEDATA[7:0] == 8'hFF |-> ##2 !$fell(IRQ);
    endproperty
    a_ones: assert property (p_ones) else $error("writing ones cleared a flag");
    property p_fall;
        $fell(IRQ) && !$past(RST) |-> $past(AVS_WRITE && !AVS_WAITREQUEST, 2);
    endproperty
    a_fall: assert property (p_fall) else $error("irq fell without a write");
endmodule
bind tsf_top tsf_chk u_chk (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ),
    .WRAP_IRQ(WRAP_IRQ), .CH_IRQ(CH_IRQ));
`default_nettype wire

// ==== verif/tb_tsf_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_tsf_top;
    logic CLK;
    logic RST = 1'b1;
    logic [4:0] AVS_ADDRESS = 5'h00;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
    logic [3:0] AVS_BYTEENABLE = 4'hF;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    logic [3:0] CAPTURE_STROBE = 4'h0;
    logic IRQ;
    logic WRAP_IRQ;
    logic [3:0] CH_IRQ;
    int fails = 0;
    int n_compared = 0;
    int seed = 32'h93dd;
    logic [31:0] r;
    logic [15:0] v;
    logic [4:0] ga;
    tsf_top dut (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .CAPTURE_STROBE(CAPTURE_STROBE), .IRQ(IRQ), .WRAP_IRQ(WRAP_IRQ), .CH_IRQ(CH_IRQ));
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Holds the request until waitrequest is sampled low, then idles one cycle
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        do begin
            @(posedge CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
        r = AVS_READDATA;
        if (n >= 50) fails++;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic test_done;
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge CLK);
        fails++;
        test_done;
    end
    initial begin
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        bus(0, 5'h00, 32'h0);
        chk(r, 32'h70);
        bus(1, 5'h00, 32'hFF);
        bus(0, 5'h00, 32'h0);
        chk(r, 32'h70);
        // A write with no byte lane enabled must leave the enables alone
        AVS_BYTEENABLE <= 4'h0;
        bus(1, 5'h04, 32'h8F);
        AVS_BYTEENABLE <= 4'hF;
        bus(0, 5'h04, 32'h0);
        chk(r, 32'h70);
        // Every compare register still holds FFFF, so the wrap sets all five flags
        bus(1, 5'h04, 32'h80);
        bus(1, 5'h0C, 32'hFFFE);
        bus(1, 5'h08, 32'h80);
        repeat (6) @(posedge CLK);
        bus(1, 5'h08, 32'h0);
        chk(WRAP_IRQ, 1'h1);
        bus(1, 5'h00, 32'h0);
        bus(0, 5'h00, 32'h0);
        chk(r, 32'hFF);
        bus(1, 5'h00, 32'hFF);
        chk(IRQ, 1'h1);
        // Requests follow an enable write one edge after the write lands
        bus(1, 5'h04, 32'h0);
        @(posedge CLK);
        chk(IRQ, 1'h0);
        bus(1, 5'h04, 32'h0F);
        @(posedge CLK);
        chk(CH_IRQ, 4'hF);
        chk(WRAP_IRQ, 1'h0);
        bus(0, 5'h00, 32'h0);
        bus(1, 5'h00, 32'h7F);
        bus(0, 5'h00, 32'h0);
        chk(r, 32'h7F);
        bus(1, 5'h00, 32'h0);
        bus(0, 5'h00, 32'h0);
        chk(r, 32'h70);
        chk(IRQ, 1'h0);
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed));
            ga = 5'(16 + 4 * i);
            bus(1, 5'h08, 32'h1 << i);
            bus(1, 5'h0C, {16'h0000, v});
            CAPTURE_STROBE <= 4'h1 << i;
            @(posedge CLK);
            CAPTURE_STROBE <= 4'h0;
            bus(0, ga, 32'h0);
            chk(r, {16'h0000, v});
            bus(0, 5'h00, 32'h0);
            chk(r, 32'h70 | (32'h1 << i));
            chk(CH_IRQ, 4'h1 << i);
            bus(1, 5'h00, 32'h0);
            bus(0, 5'h00, 32'h0);
            chk(r, 32'h70);
            bus(1, ga, {16'h0000, v + 16'h0003});
            bus(1, 5'h08, 32'h80);
            repeat (4) @(posedge CLK);
            bus(1, 5'h08, 32'h0);
            bus(0, 5'h00, 32'h0);
            chk(r & (32'h1 << i), 32'h1 << i);
            bus(1, 5'h00, 32'h0);
        end
        // Stalled counter on a compare value re-sets the flag in the clearing edge
        bus(1, 5'h0C, {16'h0000, v + 16'h0003});
        bus(0, 5'h00, 32'h0);
        bus(1, 5'h00, 32'h0);
        bus(0, 5'h00, 32'h0);
        chk(r & 32'h8, 32'h8);
        test_done;
    end
endmodule
`default_nettype wire
